// *** logic/cbh_config_regs.sv ***
// Configuration header registers 0Dh-16h of one card socket function
`timescale 1ns/1ps
module cbh_config_regs (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        cfg_sel,
   input  wire logic        cfg_wr,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output logic [31:0]      cfg_rdata,
   output logic             cfg_ext_hit,
   input  wire logic        frame_start,
   input  wire logic        tenure_active,
   input  wire logic        grant,
   output logic             tenure_end_req,
   input  wire logic        mem_sel,
   input  wire logic [31:0] mem_addr,
   output logic             win_hit,
   output logic             win_socket_hit,
   output logic             win_legacy_hit,
   output logic [11:0]      win_offset,
   input  wire logic        parity_err_ev,
   input  wire logic        card_serr_ev,
   input  wire logic        mabort_ev,
   input  wire logic        tabort_rcv_ev,
   input  wire logic        tabort_sig_ev,
   input  wire logic        card_perr,
   input  wire logic        bus_master,
   input  wire logic        parity_resp_en,
   output logic             card_serr_oe
);
   logic [7:0]  master_latency_count_r;
   logic [31:0] socket_window_base_r;
   logic [15:0] card_side_status_r;
   logic [15:0] status_set;
   logic [15:0] status_clr;
   logic [31:0] cfg_rdata_r;
   logic [31:0] rd_word;
   logic [7:0]  dw_addr;
   logic        wr_dw_c;
   logic        wr_dw_10;
   logic        wr_dw_14;
   // Dword holding latency, header type and self-test bytes
   localparam logic [7:0] DW_LAT_HDR = {cbh_pkg::OFS_MASTER_LATENCY[7:2], 2'b00};

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   // Dword-aligned address of the access
   assign dw_addr     = {cfg_addr[7:2], 2'b00};
   assign wr_dw_c     = cfg_sel && cfg_wr && dw_addr == DW_LAT_HDR;
   assign wr_dw_10    = cfg_sel && cfg_wr && dw_addr == cbh_pkg::OFS_WINDOW_BASE;
   assign wr_dw_14    = cfg_sel && cfg_wr && dw_addr == cbh_pkg::OFS_CAP_POINTER;
   // Extension space left to the vendor block
   assign cfg_ext_hit = cfg_sel && cfg_addr >= cbh_pkg::OFS_EXT_FIRST;

   ////////////////////////////////////////////////////////////////////////////
   // Master latency

   // Byte lane 1 of dword 0Ch
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         master_latency_count_r <= cbh_pkg::LATENCY_RESET;
      end else if (wr_dw_c && cfg_be[1]) begin
         master_latency_count_r <= cfg_wdata[15:8];
      end
   end

   // Tenure timer
   cbh_latency_timer u_timer (
      .clk             (clk),
      .rst_b           (rst_b),
      .frame_start     (frame_start),
      .tenure_active   (tenure_active),
      .grant           (grant),
      .latency_limit   (master_latency_count_r),
      .latency_expired (),
      .tenure_end_req  (tenure_end_req)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Window base, one per socket function

   // Only bits 31-12 take writes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         socket_window_base_r <= cbh_pkg::WINDOW_BASE_RESET;
      end else if (wr_dw_10) begin
         for (int b = 1; b < 4; b++) begin
            if (cfg_be[b]) begin
               socket_window_base_r[b*8 +: 8] <= cfg_wdata[b*8 +: 8] & cbh_pkg::WINDOW_BASE_MASK[b*8 +: 8];
            end
         end
      end
   end

   // Memory decode of the 4 KB window
   assign win_hit        = mem_sel && mem_addr[31:12] == socket_window_base_r[31:12];
   assign win_offset     = mem_addr[11:0];
   assign win_legacy_hit = win_hit && mem_addr[11:0] >= cbh_pkg::WIN_LEGACY_OFS;
   assign win_socket_hit = win_hit && mem_addr[11:0] < cbh_pkg::WIN_LEGACY_OFS && mem_addr[11:0] >= cbh_pkg::WIN_SOCKET_OFS;

   ////////////////////////////////////////////////////////////////////////////
   // Card side status

   // Hardware events
   always_comb begin
      status_set = 16'h0000;
      status_set[cbh_pkg::BIT_PARITY_DETECTED]  = parity_err_ev;
      status_set[cbh_pkg::BIT_SYS_ERROR_SEEN]   = card_serr_ev;
      status_set[cbh_pkg::BIT_MABORT_RECEIVED]  = mabort_ev;
      status_set[cbh_pkg::BIT_TABORT_RECEIVED]  = tabort_rcv_ev;
      status_set[cbh_pkg::BIT_TABORT_SIGNALLED] = tabort_sig_ev;
      status_set[cbh_pkg::BIT_DATA_PARITY]      = card_perr && bus_master && parity_resp_en;
   end

   // Write-one-to-clear on upper half of dword 14h
   always_comb begin
      status_clr = 16'h0000;
      if (wr_dw_14) begin
         if (cfg_be[2]) begin
            status_clr[7:0] = cfg_wdata[23:16];
         end
         if (cfg_be[3]) begin
            status_clr[15:8] = cfg_wdata[31:24];
         end
      end
      status_clr = status_clr & cbh_pkg::CARD_STATUS_W1C;
   end

   // Set wins over clear; fixed bits reload constant
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         card_side_status_r <= cbh_pkg::CARD_STATUS_RESET;
      end else begin
         card_side_status_r <= ((card_side_status_r & ~status_clr) | status_set) & cbh_pkg::CARD_STATUS_W1C
                               | cbh_pkg::CARD_STATUS_RESET;
      end
   end

   // Bridge never drives the card system error line
   assign card_serr_oe = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   // Dword assembly; fixed bytes are constants
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (dw_addr)
         DW_LAT_HDR: begin
            rd_word = {cbh_pkg::SELF_TEST_VALUE, cbh_pkg::HEADER_TYPE_VALUE,
                       master_latency_count_r, 8'h00};
         end
         cbh_pkg::OFS_WINDOW_BASE: begin
            rd_word = socket_window_base_r;
         end
         cbh_pkg::OFS_CAP_POINTER: begin
            rd_word = {card_side_status_r, 8'h00, cbh_pkg::CAP_POINTER_VALUE};
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   // Registered read data
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_rdata_r <= 32'h0000_0000;
      end else if (cfg_sel && !cfg_wr) begin
         cfg_rdata_r <= rd_word;
      end
   end
   assign cfg_rdata = cfg_rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   sequence status_write_one_s;
      wr_dw_14 && cfg_be[3] && cfg_wdata[31] && !parity_err_ev;
   endsequence

   // Fixed bytes and window base
   header_fixed_a: assert property (@(posedge clk) disable iff (!rst_b)
      cfg_sel && !cfg_wr && dw_addr == DW_LAT_HDR |=> cfg_rdata[31:16] == 16'h0082)
      else $error("header or self-test byte wrong");
   base_low_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
      socket_window_base_r[11:0] == 12'h000) else $error("window base low bits set");
   base_all_ones_a: assert property (@(posedge clk) disable iff (!rst_b)
      wr_dw_10 && cfg_be == 4'hF && cfg_wdata == 32'hFFFF_FFFF |=> socket_window_base_r == 32'hFFFF_F000)
      else $error("window sizing readback wrong");

   // Card status set, clear and fixed bits
   status_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
      status_write_one_s |=> !card_side_status_r[15]) else $error("status bit not cleared");
   status_set_a: assert property (@(posedge clk) disable iff (!rst_b)
      parity_err_ev |=> card_side_status_r[15]) else $error("parity event lost");
   serr_set_a: assert property (@(posedge clk) disable iff (!rst_b)
      card_serr_ev |=> card_side_status_r[14]) else $error("system error event lost");
   dpar_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      !card_side_status_r[8] && !(card_perr && bus_master && parity_resp_en) |=> !card_side_status_r[8])
      else $error("data parity bit set without cause");
   fixed_bits_a: assert property (@(posedge clk) disable iff (!rst_b)
      card_side_status_r[10:9] == cbh_pkg::SELECT_TIMING_MEDIUM && card_side_status_r[7:0] == 8'h00)
      else $error("fixed status bits wrong");
   zero_keeps_a: assert property (@(posedge clk) disable iff (!rst_b)
      wr_dw_14 && cfg_be[3] && !cfg_wdata[29] && card_side_status_r[13] |=> card_side_status_r[13])
      else $error("zero write cleared a status bit");

   ////////////////////////////////////////////////////////////////////////////
   // Register bus checks

   // Reads of each implemented dword
   sequence read_lat_dw_s;
      cfg_sel && !cfg_wr && dw_addr == DW_LAT_HDR;
   endsequence
   sequence read_base_dw_s;
      cfg_sel && !cfg_wr && dw_addr == cbh_pkg::OFS_WINDOW_BASE;
   endsequence
   sequence read_cap_dw_s;
      cfg_sel && !cfg_wr && dw_addr == cbh_pkg::OFS_CAP_POINTER;
   endsequence

   // Reads outside the implemented dwords
   sequence read_unmapped_s;
      cfg_sel && !cfg_wr && dw_addr != DW_LAT_HDR && dw_addr != cbh_pkg::OFS_WINDOW_BASE
         && dw_addr != cbh_pkg::OFS_CAP_POINTER;
   endsequence

   // Cycles that leave the read data alone
   sequence idle_or_write_s;
      !(cfg_sel && !cfg_wr);
   endsequence

   // Writes to writable fields, and status writes with the upper lane off
   sequence lat_write_s;
      wr_dw_c && cfg_be[1];
   endsequence
   sequence base_top_write_s;
      wr_dw_10 && cfg_be[3];
   endsequence
   sequence upper_lane_off_s;
      wr_dw_14 && !cfg_be[3];
   endsequence

   // Read data one cycle after the request
   lat_readback_a: assert property (@(posedge clk) disable iff (!rst_b)
      read_lat_dw_s |=> cfg_rdata[15:8] == $past(master_latency_count_r))
      else $error("latency readback wrong");
   self_test_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
      read_lat_dw_s |=> cfg_rdata[31:24] == cbh_pkg::SELF_TEST_VALUE && cfg_rdata[7:0] == 8'h00)
      else $error("self-test byte not zero");
   base_readback_a: assert property (@(posedge clk) disable iff (!rst_b)
      read_base_dw_s |=> cfg_rdata == $past(socket_window_base_r))
      else $error("window base readback wrong");
   cap_readback_a: assert property (@(posedge clk) disable iff (!rst_b)
      read_cap_dw_s |=> cfg_rdata[15:0] == {8'h00, cbh_pkg::CAP_POINTER_VALUE})
      else $error("capability pointer wrong");
   status_readback_a: assert property (@(posedge clk) disable iff (!rst_b)
      read_cap_dw_s |=> cfg_rdata[31:16] == $past(card_side_status_r))
      else $error("card status readback wrong");
   unmapped_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
      read_unmapped_s |=> cfg_rdata == 32'h0000_0000)
      else $error("unmapped dword not zero");

   // Read data stands until the next read
   rdata_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      idle_or_write_s |=> $stable(cfg_rdata))
      else $error("read data changed without a read");

   // Extension space flag
   ext_hit_a: assert property (@(posedge clk) disable iff (!rst_b)
      cfg_sel && cfg_addr[7] |-> cfg_ext_hit)
      else $error("extension access not flagged");
   ext_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
      !(cfg_sel && cfg_addr[7]) |-> !cfg_ext_hit)
      else $error("standard header access flagged as extension");

   // Writable fields take their lane, everything else keeps
   lat_write_a: assert property (@(posedge clk) disable iff (!rst_b)
      lat_write_s |=> master_latency_count_r == $past(cfg_wdata[15:8]))
      else $error("latency write lost");
   lat_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
      !(wr_dw_c && cfg_be[1]) |=> $stable(master_latency_count_r))
      else $error("latency changed without a write");
   base_write_a: assert property (@(posedge clk) disable iff (!rst_b)
      base_top_write_s |=> socket_window_base_r[31:24] == $past(cfg_wdata[31:24]))
      else $error("window base write lost");
   base_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
      !wr_dw_10 |=> $stable(socket_window_base_r))
      else $error("window base changed without a write");
   base_lane_a: assert property (@(posedge clk) disable iff (!rst_b)
      wr_dw_10 && !cfg_be[2] |=> $stable(socket_window_base_r[23:16]))
      else $error("disabled lane of window base written");

   ////////////////////////////////////////////////////////////////////////////
   // Window and card side checks

   // Window decode
   window_match_a: assert property (@(posedge clk) disable iff (!rst_b)
      mem_sel && mem_addr[31:12] == socket_window_base_r[31:12] |-> win_hit)
      else $error("window access missed");
   window_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
      !mem_sel |-> !win_hit && !win_socket_hit && !win_legacy_hit)
      else $error("window hit without access");
   window_split_a: assert property (@(posedge clk) disable iff (!rst_b)
      win_hit |-> win_legacy_hit == mem_addr[11] && win_socket_hit == !mem_addr[11])
      else $error("window halves decoded wrong");
   one_region_a: assert property (@(posedge clk) disable iff (!rst_b)
      !(win_socket_hit && win_legacy_hit))
      else $error("both window halves hit");

   // Card events set their own bits
   mabort_set_a: assert property (@(posedge clk) disable iff (!rst_b)
      mabort_ev |=> card_side_status_r[cbh_pkg::BIT_MABORT_RECEIVED])
      else $error("master abort event lost");
   tabort_rcv_a: assert property (@(posedge clk) disable iff (!rst_b)
      tabort_rcv_ev |=> card_side_status_r[cbh_pkg::BIT_TABORT_RECEIVED])
      else $error("received target abort lost");
   tabort_sig_a: assert property (@(posedge clk) disable iff (!rst_b)
      tabort_sig_ev |=> card_side_status_r[cbh_pkg::BIT_TABORT_SIGNALLED])
      else $error("signalled target abort lost");
   dpar_set_a: assert property (@(posedge clk) disable iff (!rst_b)
      card_perr && bus_master && parity_resp_en |=> card_side_status_r[cbh_pkg::BIT_DATA_PARITY])
      else $error("data parity report lost");

   // An event beats a clear in the same cycle
   set_beats_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
      mabort_ev && wr_dw_14 && cfg_be[3] && cfg_wdata[29] |=> card_side_status_r[13])
      else $error("clear won over a new event");

   // Bits drop only by a write of one on an enabled lane
   status_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
      !wr_dw_14 |=> ($past(card_side_status_r) & ~card_side_status_r) == 16'h0000)
      else $error("status bit dropped without a write");
   lane_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      upper_lane_off_s |=> ($past(card_side_status_r[15:8]) & ~card_side_status_r[15:8]) == 8'h00)
      else $error("disabled lane cleared a status bit");

   // Bridge output stays quiet
   serr_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
      !card_serr_oe) else $error("card system error driven");
endmodule // cbh_config_regs

// *** logic/cbh_pkg.sv ***
// Constants for the card bridge configuration header slice
package cbh_pkg;
   localparam logic [7:0]  OFS_MASTER_LATENCY  = 8'h0D;
   localparam logic [7:0]  OFS_HEADER_TYPE     = 8'h0E;
   localparam logic [7:0]  OFS_SELF_TEST       = 8'h0F;
   localparam logic [7:0]  OFS_WINDOW_BASE     = 8'h10;
   localparam logic [7:0]  OFS_CAP_POINTER     = 8'h14;
   localparam logic [7:0]  OFS_CARD_STATUS     = 8'h16;
   localparam logic [7:0]  OFS_EXT_FIRST       = 8'h80;
   localparam logic [7:0]  LATENCY_RESET       = 8'h00;
   localparam logic [7:0]  HEADER_TYPE_VALUE   = 8'h82;
   localparam logic [7:0]  SELF_TEST_VALUE     = 8'h00;
   localparam logic [7:0]  CAP_POINTER_VALUE   = 8'hA0;
   localparam logic [7:0]  PM_CAP_DWORD        = 8'hA0;
   localparam logic [7:0]  PM_CSR_DWORD        = 8'hA4;
   localparam logic [31:0] WINDOW_BASE_RESET   = 32'h0000_0000;
   localparam logic [31:0] WINDOW_BASE_MASK    = 32'hFFFF_F000;
   localparam logic [11:0] WIN_SOCKET_OFS      = 12'h000;
   localparam logic [11:0] WIN_LEGACY_OFS      = 12'h800;
   localparam logic [15:0] CARD_STATUS_RESET   = 16'h0200;
   localparam logic [15:0] CARD_STATUS_W1C     = 16'hF900;
   localparam int          BIT_PARITY_DETECTED = 15;
   localparam int          BIT_SYS_ERROR_SEEN  = 14;
   localparam int          BIT_MABORT_RECEIVED = 13;
   localparam int          BIT_TABORT_RECEIVED = 12;
   localparam int          BIT_TABORT_SIGNALLED = 11;
   localparam int          BIT_DATA_PARITY     = 8;
   localparam logic [1:0]  SELECT_TIMING_MEDIUM = 2'h1;
   localparam int          CARD_CLK_MAX_MHZ    = 33;
endpackage : cbh_pkg

// *** logic/cbh_latency_timer.sv ***
// Master latency timer that ends over-long bus tenures
`timescale 1ns/1ps
module cbh_latency_timer (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       frame_start,
   input  wire logic       tenure_active,
   input  wire logic       grant,
   input  wire logic [7:0] latency_limit,
   output logic            latency_expired,
   output logic            tenure_end_req
);
   logic [7:0] count_r;
   logic       expired_r;

   // Count from zero at frame start, saturate at FFh
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count_r <= 8'h00;
      end else if (frame_start) begin
         count_r <= 8'h00;
      end else if (tenure_active && count_r != 8'hFF) begin
         count_r <= count_r + 8'h01;
      end
   end

   // Expiry flag held until next frame
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         expired_r <= 1'b0;
      end else if (frame_start) begin
         expired_r <= 1'b0;
      end else if (tenure_active && count_r >= latency_limit) begin
         expired_r <= 1'b1;
      end
   end

   assign latency_expired = expired_r;
   assign tenure_end_req  = expired_r && tenure_active && !grant;

   // Count has reached the limit inside the own tenure
   sequence limit_reached_s;
      !frame_start && tenure_active && count_r >= latency_limit;
   endsequence

   restart_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
      frame_start |=> count_r == 8'h00) else $error("latency count not restarted");
   count_step_a: assert property (@(posedge clk) disable iff (!rst_b)
      !frame_start && tenure_active && count_r < 8'hFE |=> count_r == $past(count_r) + 8'h01)
      else $error("latency count did not advance");
   end_on_grant_a: assert property (@(posedge clk) disable iff (!rst_b)
      limit_reached_s ##1 (tenure_active && !grant) |-> tenure_end_req) else $error("tenure not ended");
   hold_with_grant_a: assert property (@(posedge clk) disable iff (!rst_b)
      tenure_end_req |-> !grant && count_r != 8'h00) else $error("tenure ended while granted or early");
endmodule // cbh_latency_timer

// *** test/cbh_card_model.sv ***
// Card-side partner that raises one error event pulse on request
`timescale 1ns/1ps
module cbh_card_model (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       ev_go,
   input  wire logic [2:0] ev_code,
   input  wire logic [1:0] ev_dly,
   output logic            parity_err_ev,
   output logic            card_serr_ev,
   output logic            mabort_ev,
   output logic            tabort_rcv_ev,
   output logic            tabort_sig_ev
);
   logic       pend_r;
   logic [1:0] wait_r;
   logic [2:0] code_r;
   logic       fire;
   ////////////////////////////////////////////////////////////
   // Hold one request, count down its delay, then fire once
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_r <= 1'b0;
         wait_r <= 2'h0;
         code_r <= 3'h0;
      end else if (ev_go) begin
         pend_r <= 1'b1;
         wait_r <= ev_dly;
         code_r <= ev_code;
      end else if (pend_r && wait_r != 2'h0) begin
         wait_r <= wait_r - 2'h1;
      end else begin
         pend_r <= 1'b0;
      end
   end
   // One-cycle event pulses, one code each
   assign fire          = pend_r && (wait_r == 2'h0);
   assign parity_err_ev = fire && (code_r == 3'h0);
   assign card_serr_ev  = fire && (code_r == 3'h1);
   assign mabort_ev     = fire && (code_r == 3'h2);
   assign tabort_rcv_ev = fire && (code_r == 3'h3);
   assign tabort_sig_ev = fire && (code_r == 3'h4);
endmodule // cbh_card_model

// *** test/cbh_config_regs_tb.sv ***
// Self-checking bench for one socket's configuration header slice
`timescale 1ns/1ps
module cbh_config_regs_tb;
   logic        clk, rst_b, cfg_sel, cfg_wr, frame_start, tenure_active, grant, mem_sel, ev_go;
   logic        cfg_ext_hit, tenure_end_req, win_hit, win_socket_hit, win_legacy_hit, card_serr_oe;
   logic        pe, se, ma, tr, ts, card_perr, bus_master, parity_resp_en;
   logic [7:0]  cfg_addr, lat;
   logic [3:0]  cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata, mem_addr, base, d;
   logic [11:0] win_offset;
   logic [2:0]  ev_code;
   logic [1:0]  ev_dly;
   logic [15:0] stat;
   int          miscompares, compares, cycles;
   int          offs[5] = '{32'h0, 32'h7FF, 32'h800, 32'hFFF, 32'h1000};
   ////////////////////////////////////////////////////////////
   // Design and card partner
   cbh_config_regs DUT (.clk(clk), .rst_b(rst_b), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
      .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ext_hit(cfg_ext_hit),
      .frame_start(frame_start), .tenure_active(tenure_active), .grant(grant),
      .tenure_end_req(tenure_end_req), .mem_sel(mem_sel), .mem_addr(mem_addr), .win_hit(win_hit),
      .win_socket_hit(win_socket_hit), .win_legacy_hit(win_legacy_hit), .win_offset(win_offset),
      .parity_err_ev(pe), .card_serr_ev(se), .mabort_ev(ma), .tabort_rcv_ev(tr), .tabort_sig_ev(ts),
      .card_perr(card_perr), .bus_master(bus_master), .parity_resp_en(parity_resp_en),
      .card_serr_oe(card_serr_oe));
   cbh_card_model card (.clk(clk), .rst_b(rst_b), .ev_go(ev_go), .ev_code(ev_code), .ev_dly(ev_dly),
      .parity_err_ev(pe), .card_serr_ev(se), .mabort_ev(ma), .tabort_rcv_ev(tr), .tabort_sig_ev(ts));
   ////////////////////////////////////////////////////////////
   // Compare, bus cycle, event and closing tasks
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
      @(posedge clk);
      cfg_sel <= 1'b1;
      cfg_wr <= w;
      cfg_addr <= a;
      cfg_be <= be;
      cfg_wdata <= wd;
      #1 chk("ext_hit", {31'h0, cfg_ext_hit}, {31'h0, a[7]});
      @(posedge clk);
      cfg_sel <= 1'b0;
      #1;
   endtask
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
      acc(1'b0, a, 4'hF, 32'h0);
      chk(n, cfg_rdata, e);
   endtask
   task automatic card_ev(input int c, input int dl);
      @(posedge clk);
      ev_go <= 1'b1;
      ev_code <= 3'(c);
      ev_dly <= 2'(dl);
      @(posedge clk);
      ev_go <= 1'b0;
      repeat (dl + 2) @(posedge clk);
   endtask
   task automatic close_out;
      if (miscompares == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         close_out;
      end
   end
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {rst_b, cfg_sel, cfg_wr, frame_start, tenure_active, grant, mem_sel, ev_go} = 8'h00;
      {card_perr, bus_master, parity_resp_en, ev_code, ev_dly} = 8'h00;
      {cfg_addr, cfg_be, cfg_wdata, mem_addr} = 76'h0;
      void'($urandom(96));
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      stat = 16'h0200;
      rd("hdr_dw", 8'h0C, 32'h0082_0000);
      rd("base_rst", 8'h10, 32'h0);
      rd("cap_stat", 8'h14, {stat, 16'h00A0});
      chk("serr_oe", {31'h0, card_serr_oe}, 32'h0);
      // Latency byte lane, then read-only neighbours under full writes
      d = $urandom;
      acc(1'b1, 8'h0C, 4'h2, d);
      rd("lat", 8'h0C, {16'h0082, d[15:8], 8'h00});
      acc(1'b1, 8'h0C, 4'hF, 32'hFFFF_FFFF);
      rd("hdr_ro", 8'h0C, 32'h0082_FF00);
      acc(1'b1, 8'h14, 4'hF, 32'hFFFF_FFFF);
      rd("cap_ro", 8'h14, {stat, 16'h00A0});
      // Window sizing, random base, decode across boundaries
      acc(1'b1, 8'h10, 4'hF, 32'hFFFF_FFFF);
      rd("size", 8'h10, 32'hFFFF_F000);
      d = $urandom & 32'h7FFF_FFFF;
      base = d & 32'hFFFF_F000;
      acc(1'b1, 8'h10, 4'hF, d);
      rd("base", 8'h10, base);
      rd("unmapped", 8'h40, 32'h0);
      rd("ext_space", 8'hC4, 32'h0);
      foreach (offs[i]) begin
         @(posedge clk);
         mem_sel <= 1'b1;
         mem_addr <= base + offs[i];
         #1 chk("win", {17'h0, win_hit, win_socket_hit, win_legacy_hit, win_hit ? win_offset : 12'h0},
            {17'h0, offs[i] < 4096, offs[i] < 2048, offs[i] >= 2048 && offs[i] < 4096,
             offs[i] < 4096 ? offs[i][11:0] : 12'h0});
      end
      // Card events, prompt and slow, then random clear masks
      for (int c = 0; c < 5; c++) begin
         card_ev(c, c % 4);
         stat[15-c] = 1'b1;
         rd("ev_set", 8'h14, {stat, 16'h00A0});
      end
      repeat (3) begin
         d = $urandom;
         acc(1'b1, 8'h14, 4'hC, d);
         stat = stat & ~(d[31:16] & 16'hF900);
         rd("w1c", 8'h14, {stat, 16'h00A0});
      end
      // Data parity bit only with all three conditions
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         {card_perr, bus_master, parity_resp_en} <= 3'(i);
         @(posedge clk);
         {card_perr, bus_master, parity_resp_en} <= 3'h0;
         stat[8] = (i == 7);
         rd("dpar", 8'h14, {stat, 16'h00A0});
         acc(1'b1, 8'h14, 4'hC, 32'h0100_0000);
         stat[8] = 1'b0;
      end
      // Latency expiry, grant gating and restart from zero
      acc(1'b1, 8'h0C, 4'h2, 32'h0000_0400);
      repeat (2) begin
         @(posedge clk);
         frame_start <= 1'b1;
         tenure_active <= 1'b1;
         grant <= 1'b1;
         @(posedge clk);
         frame_start <= 1'b0;
         grant <= 1'b0;
         @(posedge clk);
         #1 chk("early", {31'h0, tenure_end_req}, 32'h0);
         repeat (3) @(posedge clk);
         #1 chk("not_yet", {31'h0, tenure_end_req}, 32'h0);
         @(posedge clk);
         #1 chk("expire", {31'h0, tenure_end_req}, 32'h1);
         @(posedge clk);
         grant <= 1'b1;
         #1 chk("granted", {31'h0, tenure_end_req}, 32'h0);
         @(posedge clk);
         tenure_active <= 1'b0;
      end
      close_out;
   end
endmodule // cbh_config_regs_tb
